// file: core/tlb_check_regs.svh
// Purpose: Register offsets, field positions and timing counts.
// Assumes: Byte addresses on the register bus, one word per register.
// Notes:   Definitions only.
`ifndef TLB_CHECK_REGS_SVH
`define TLB_CHECK_REGS_SVH
`define OFS_CTRL    8'h00
`define OFS_PID     8'h04
`define OFS_ZONE    8'h08
`define OFS_CFG     8'h0c
`define OFS_ENT_HI  8'h10
`define OFS_ENT_LO  8'h14
`define OFS_ENT_TID 8'h18
`define OFS_ENT_WR  8'h1c
`define OFS_STATUS  8'h20
`define CTRL_DX     0
`define CTRL_IX     1
`define CFG_USER_ATTR_EXC_ENABLE    0
`define HI_TAG      31:10
`define HI_SIZE     9:7
`define HI_VALID    6
`define HI_ENDIAN   5
`define HI_U0       4
`define LO_RPN      31:10
`define LO_EX       9
`define LO_WR       8
`define LO_ZONE_SELECTOR     7:4
`define LO_W        3
`define LO_I        2
`define LO_M        1
`define LO_G        0
`define WR_IDX      3:0
`define SHD_N       4
`define UNI_N       16
`define DS_MISS_CYC 3'h3
`define IF_MISS_CYC 3'h4
`define TAG_ALL     22'h3fffff
`define ZONE_NONE   2'h0
`define ZONE_PRIV   2'h2
`define ZONE_FULL   2'h3
`define TID_SHARED  8'h00
`endif

// file: core/tlb_check_pkg.sv
// Purpose: Types shared by the translation lookup block.
// Assumes: Nothing beyond the register header.
// Notes:   States are one-hot.
package tlb_check_pkg;
	typedef struct packed {
		logic        valid;
		logic [21:0] tag;
		logic [2:0]  size;
		logic        endian;
		logic        u0;
		logic [7:0]  entry_process_tag;
		logic [21:0] real_page_number;
		logic        ex;
		logic        wr;
		logic [3:0]  zone_selector;
		logic        w;
		logic        i;
		logic        m;
		logic        g;
	} entry_t;
	typedef enum logic [3:0] {
		OP_LOAD   = 4'h0,
		OP_STORE  = 4'h1,
		OP_FLUSH  = 4'h2,
		OP_STBACK = 4'h3,
		OP_ZERO   = 4'h4,
		OP_INVAL  = 4'h5,
		OP_CCINV  = 4'h6,
		OP_ICINV  = 4'h7,
		OP_ICCINV = 4'h8,
		OP_TOUCH  = 4'h9
	} op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_WALK = 3'h4
	} st_t;
endpackage

// file: core/tlb_lookup_access_check.sv
// Purpose: Shadow and unified translation lookup with access checks.
// Assumes: Requests are one-cycle pulses taken only while not busy.
// Notes:   Index 0 is the data side, index 1 the instruction side.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "tlb_check_regs.svh"
// Notes on behaviour
// - Search the side's shadow buffer first; unified buffer only on shadow miss.
// - Instruction shadow miss resolved from unified buffer stalls four cycles.
// - Data shadow miss resolved from unified buffer stalls three cycles.
// - Data side wins the unified buffer when both ask together.
// - Parallel compare of valid, size-masked tag and process tag.
// - Entry process tag zero matches every process.
// - Process id zero hits only entries with process tag zero.
// - Physical address is masked real page number with page offset.
// - Permissions are judged before caching and byte-order attributes apply.
// - An interrupt clears both translation enables, entering real mode.
// - User no-access zone faults loads, stores and listed block operations.
// - User write to read-only page faults unless zone is 11.
// - Privileged write-type to read-only page faults unless zone 10 or 11.
// - User attribute with its enable faults write-type operations.
// - User fetch through a no-access zone is an instruction fault.
// - Fetch from non-executable page faults unless zone overrides.
// - Fetch from a guarded page faults in either mode.
// - Instruction fault is raised at execution, not at fetch.
// - Data miss with translation on, except for cache-touch operations.
// - Instruction fetch with no match raises an instruction miss.
// - Checks only with translation on; privileged reads never denied.
// - Zone selector picks one of sixteen 2-bit override fields.
// - Size code selects 1 KB to 16 MB pages, masking tag bits.
module tlb_lookup_access_check (
	// Clock and reset
	input  wire logic                  ref_clk_in,
	input  wire logic                  resetn_in,
	// Register bus
	input  wire logic                  hsel_in,
	input  wire logic [31:0]           haddr_in,
	input  wire logic [1:0]            htrans_in,
	input  wire logic                  hwrite_in,
	input  wire logic [2:0]            hsize_in,
	input  wire logic [31:0]           hwdata_in,
	input  wire logic                  hready_in,
	output logic      [31:0]           hrdata_out,
	output logic                       hreadyout_out,
	output logic                       hresp_out,
	// Core state
	input  wire logic                  user_mode_in,
	input  wire logic                  irq_in,
	// Data side
	input  wire logic                  ds_req_in,
	input  wire logic [31:0]           ds_ea_in,
	input  wire tlb_check_pkg::op_t    ds_op_in,
	output logic                       ds_done_out,
	output logic                       ds_busy_out,
	output logic      [31:0]           ds_pa_out,
	output logic                       ds_mem_en_out,
	output logic      [3:0]            ds_attr_out,
	output logic                       ds_miss_out,
	output logic                       ds_fault_out,
	// Instruction side
	input  wire logic                  if_req_in,
	input  wire logic [31:0]           if_ea_in,
	input  wire logic                  if_exec_in,
	input  wire logic                  if_exec_tag_in,
	output logic                       if_done_out,
	output logic                       if_busy_out,
	output logic      [31:0]           if_pa_out,
	output logic                       if_mem_en_out,
	output logic                       if_miss_out,
	output logic                       if_isf_tag_out,
	output logic                       instr_storage_fault_out
);
	import tlb_check_pkg::*;

	entry_t              uni_ff [`UNI_N];
	entry_t              shd_ff [2][`SHD_N];
	st_t                 st_ff  [2];
	st_t                 nxt_st [2];
	logic [2:0]          cnt_ff [2];
	logic [31:0]         ea_ff  [2];
	logic [1:0]          vic_ff [2];
	op_t                 op_ff;
	logic                dx_ff;
	logic                ix_ff;
	logic [7:0]          pid_ff;
	logic [31:0]         zpr_ff;
	logic                user_attr_exc_enable_ff;
	logic [31:0]         hi_ff;
	logic [31:0]         lo_ff;
	logic [7:0]          tid_ff;
	logic                rd_pend_ff;
	logic                wr_pend_ff;
	logic [7:0]          addr_ff;
	logic [31:0]         rd_mux;
	logic                ap;
	logic                commit;
	entry_t              new_ent;
	logic [31:0]         ea_in  [2];
	logic [31:0]         cur_ea [2];
	logic [`SHD_N-1:0]   sh_hit [2];
	logic [`UNI_N-1:0]   u_hit;
	logic [31:0]         u_ea;
	entry_t              ent    [2];
	logic [1:0]          req;
	logic [1:0]          xon;
	logic [1:0]          take;
	logic [1:0]          walk_end;
	logic [1:0]          found;
	logic [1:0]          finish;
	logic [1:0]          want;
	logic [1:0]          grant;
	logic [1:0]          over;
	logic [1:0]          nozone;
	logic [1:0]          viol;
	logic [1:0]          miss;
	logic [1:0]          zone   [2];
	logic [31:0]         pa     [2];
	logic                uni_busy;
	op_t                 cur_op;
	logic                is_wr;
	logic                zone_op;
	logic                d_bad;
	logic                i_bad;
	logic                touch;

	function automatic logic [21:0] mask_f(input logic [2:0] sz);
		mask_f = `TAG_ALL << {sz, 1'b0};
	endfunction

	function automatic logic hit_f(input entry_t e, input logic [31:0] ea,
		input logic [7:0] process_id_reg);
		logic [21:0] m;
		m = mask_f(e.size);
		hit_f = e.valid && ((e.tag & m) == (ea[31:10] & m)) &&
			(e.entry_process_tag == `TID_SHARED || e.entry_process_tag == process_id_reg);
	endfunction

	function automatic logic [3:0] first_f(input logic [15:0] v);
		first_f = 4'h0;
		for (int k = 15; k >= 0; k--) begin
			if (v[k]) begin
				first_f = k[3:0];
			end
		end
	endfunction

	assign req[0]   = ds_req_in;
	assign req[1]   = if_req_in;
	assign ea_in[0] = ds_ea_in;
	assign ea_in[1] = if_ea_in;
	assign xon[0]   = dx_ff;
	assign xon[1]   = ix_ff;
	assign uni_busy = st_ff[0] == ST_WALK || st_ff[1] == ST_WALK;
	assign u_ea     = st_ff[1] == ST_WALK ? ea_ff[1] : ea_ff[0];

	for (genvar k = 0; k < `UNI_N; k++) begin : g_uni
		assign u_hit[k] = hit_f(uni_ff[k], u_ea, pid_ff);
	end

	for (genvar s = 0; s < 2; s++) begin : g_side
		for (genvar k = 0; k < `SHD_N; k++) begin : g_shd
			assign sh_hit[s][k] = hit_f(shd_ff[s][k], cur_ea[s], pid_ff);
		end
		assign cur_ea[s]   = st_ff[s] == ST_IDLE ? ea_in[s] : ea_ff[s];
		assign take[s]     = st_ff[s] == ST_IDLE && req[s];
		assign walk_end[s] = st_ff[s] == ST_WALK && cnt_ff[s] == 3'h0;
		assign ent[s]   = walk_end[s] ? uni_ff[first_f(u_hit)] :
			shd_ff[s][2'(first_f({12'h000, sh_hit[s]}))];
		assign found[s] = walk_end[s] ? |u_hit : |sh_hit[s];
		assign finish[s] = (take[s] && (!xon[s] || found[s])) || walk_end[s];
		assign want[s]   = (take[s] && xon[s] && !found[s]) ||
			st_ff[s] == ST_WAIT;
		assign pa[s] = {(ent[s].real_page_number & mask_f(ent[s].size)) |
			(cur_ea[s][31:10] & ~mask_f(ent[s].size)), cur_ea[s][9:0]};
		assign zone[s]   = zpr_ff[{~ent[s].zone_selector, 1'b1} -: 2];
		assign over[s]   = zone[s] == `ZONE_FULL ||
			(!user_mode_in && zone[s] == `ZONE_PRIV);
		assign nozone[s] = user_mode_in && zone[s] == `ZONE_NONE;
		assign miss[s] = xon[s] && !found[s];

		always_comb begin
			nxt_st[s] = st_ff[s];
			case (st_ff[s])
			ST_IDLE: begin
				if (grant[s]) begin
					nxt_st[s] = ST_WALK;
				end else if (want[s]) begin
					nxt_st[s] = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (grant[s]) begin
					nxt_st[s] = ST_WALK;
				end
			end
			ST_WALK: begin
				if (cnt_ff[s] == 3'h0) begin
					nxt_st[s] = ST_IDLE;
				end
			end
			default: nxt_st[s] = ST_IDLE;
			endcase
		end

		always_ff @(posedge ref_clk_in) begin
			if (!resetn_in) begin
				st_ff[s]  <= ST_IDLE;
				cnt_ff[s] <= 3'h0;
				ea_ff[s]  <= 32'h0;
			end else begin
				st_ff[s] <= nxt_st[s];
				if (take[s]) begin
					ea_ff[s] <= ea_in[s];
				end
				if (grant[s]) begin
					cnt_ff[s] <= (s == 0 ? `DS_MISS_CYC : `IF_MISS_CYC) - 3'h1;
				end else if (st_ff[s] == ST_WALK && cnt_ff[s] != 3'h0) begin
					cnt_ff[s] <= cnt_ff[s] - 3'h1;
				end
			end
		end
	end

	assign grant[0] = want[0] && !uni_busy;
	assign grant[1] = want[1] && !want[0] && !uni_busy;

	assign cur_op  = st_ff[0] == ST_IDLE ? ds_op_in : op_ff;
	assign touch   = cur_op == OP_TOUCH;
	assign is_wr   = cur_op == OP_STORE || cur_op == OP_ZERO ||
		(!user_mode_in && (cur_op == OP_INVAL || cur_op == OP_CCINV));
	assign zone_op = cur_op != OP_INVAL && cur_op != OP_CCINV &&
		cur_op != OP_ICCINV;
	assign d_bad = (nozone[0] && zone_op) ||
		(is_wr && !ent[0].wr && !over[0]) ||
		(is_wr && ent[0].u0 && user_attr_exc_enable_ff);
	assign i_bad = nozone[1] || (!ent[1].ex && !over[1]) || ent[1].g;
	assign viol[0] = xon[0] && found[0] && d_bad;
	assign viol[1] = xon[1] && found[1] && i_bad;

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			op_ff <= OP_LOAD;
		end else if (take[0]) begin
			op_ff <= ds_op_in;
		end
	end

	// Refilling from the unified buffer keeps the two shadows warm; a new
	// unified entry flushes both shadows so no stale copy can hit.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in || commit) begin
			for (int s = 0; s < 2; s++) begin
				for (int k = 0; k < `SHD_N; k++) begin
					shd_ff[s][k].valid <= 1'b0;
				end
				if (!resetn_in) begin
					vic_ff[s] <= 2'h0;
				end
			end
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (walk_end[s] && found[s]) begin
					shd_ff[s][vic_ff[s]] <= ent[s];
					vic_ff[s]            <= vic_ff[s] + 2'h1;
				end
			end
		end
	end

	assign commit  = wr_pend_ff && addr_ff == `OFS_ENT_WR;
	assign new_ent = '{valid: hi_ff[`HI_VALID], tag: hi_ff[`HI_TAG],
		size: hi_ff[`HI_SIZE], endian: hi_ff[`HI_ENDIAN], u0: hi_ff[`HI_U0],
		entry_process_tag: tid_ff, real_page_number: lo_ff[`LO_RPN], ex: lo_ff[`LO_EX], wr: lo_ff[`LO_WR],
		zone_selector: lo_ff[`LO_ZONE_SELECTOR], w: lo_ff[`LO_W], i: lo_ff[`LO_I],
		m: lo_ff[`LO_M], g: lo_ff[`LO_G]};

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			for (int k = 0; k < `UNI_N; k++) begin
				uni_ff[k].valid <= 1'b0;
			end
		end else if (commit) begin
			uni_ff[hwdata_in[`WR_IDX]] <= new_ent;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			ds_done_out   <= 1'b0;
			ds_pa_out     <= 32'h0;
			ds_mem_en_out <= 1'b0;
			ds_attr_out   <= 4'h0;
			ds_miss_out   <= 1'b0;
			ds_fault_out  <= 1'b0;
			ds_busy_out   <= 1'b0;
		end else begin
			ds_done_out <= finish[0];
			ds_busy_out <= nxt_st[0] != ST_IDLE;
			if (finish[0]) begin
				ds_pa_out     <= xon[0] ? pa[0] : cur_ea[0];
				ds_mem_en_out <= !miss[0] && !viol[0];
				ds_attr_out   <= (xon[0] && found[0] && !viol[0]) ?
					{ent[0].endian, ent[0].w, ent[0].i, ent[0].g} : 4'h0;
				ds_miss_out   <= miss[0] && !touch;
				ds_fault_out  <= viol[0] && !touch;
			end else begin
				ds_mem_en_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			if_done_out    <= 1'b0;
			if_pa_out      <= 32'h0;
			if_mem_en_out  <= 1'b0;
			if_miss_out    <= 1'b0;
			if_isf_tag_out <= 1'b0;
			if_busy_out    <= 1'b0;
		end else begin
			if_done_out <= finish[1];
			if_busy_out <= nxt_st[1] != ST_IDLE;
			if (finish[1]) begin
				if_pa_out      <= xon[1] ? pa[1] : cur_ea[1];
				if_mem_en_out  <= !miss[1] && !viol[1];
				if_miss_out    <= miss[1];
				if_isf_tag_out <= viol[1];
			end else begin
				if_mem_en_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			instr_storage_fault_out <= 1'b0;
		end else begin
			instr_storage_fault_out <= if_exec_in && if_exec_tag_in;
		end
	end

	// Reads take one wait state so a write just before is always seen.
	assign ap = hsel_in && htrans_in[1] && hready_in;

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			rd_pend_ff    <= 1'b0;
			wr_pend_ff    <= 1'b0;
			addr_ff       <= 8'h0;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			hrdata_out    <= 32'h0;
		end else begin
			rd_pend_ff    <= ap && !hwrite_in;
			wr_pend_ff    <= ap && hwrite_in;
			hreadyout_out <= !(ap && !hwrite_in);
			if (ap) begin
				addr_ff <= haddr_in[7:0];
			end
			if (rd_pend_ff) begin
				hrdata_out <= rd_mux;
			end
		end
	end

	always_comb begin
		case (addr_ff)
		`OFS_CTRL:    rd_mux = {30'h0, ix_ff, dx_ff};
		`OFS_PID:     rd_mux = {24'h0, pid_ff};
		`OFS_ZONE:    rd_mux = zpr_ff;
		`OFS_CFG:     rd_mux = {31'h0, user_attr_exc_enable_ff};
		`OFS_ENT_HI:  rd_mux = hi_ff;
		`OFS_ENT_LO:  rd_mux = lo_ff;
		`OFS_ENT_TID: rd_mux = {24'h0, tid_ff};
		`OFS_STATUS:  rd_mux = {26'h0, if_busy_out, ds_busy_out,
			if_isf_tag_out, if_miss_out, ds_fault_out, ds_miss_out};
		default:      rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			dx_ff   <= 1'b0;
			ix_ff   <= 1'b0;
			pid_ff  <= 8'h0;
			zpr_ff  <= 32'h0;
			user_attr_exc_enable_ff <= 1'b0;
			hi_ff   <= 32'h0;
			lo_ff   <= 32'h0;
			tid_ff  <= 8'h0;
		end else begin
			if (wr_pend_ff) begin
				case (addr_ff)
				`OFS_CTRL: begin
					dx_ff <= hwdata_in[`CTRL_DX];
					ix_ff <= hwdata_in[`CTRL_IX];
				end
				`OFS_PID:     pid_ff  <= hwdata_in[7:0];
				`OFS_ZONE:    zpr_ff  <= hwdata_in;
				`OFS_CFG:     user_attr_exc_enable_ff <= hwdata_in[`CFG_USER_ATTR_EXC_ENABLE];
				`OFS_ENT_HI:  hi_ff   <= hwdata_in;
				`OFS_ENT_LO:  lo_ff   <= hwdata_in;
				`OFS_ENT_TID: tid_ff  <= hwdata_in[7:0];
				default: begin
				end
				endcase
			end
			if (irq_in) begin
				dx_ff <= 1'b0;
				ix_ff <= 1'b0;
			end
		end
	end
endmodule

// file: verification/lookup_checker.sv
// Purpose: Port-level assertions for the translation lookup block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Attached to the design by the bind below.
`timescale 1ns/1ns
module lookup_checker (
	// Clock and reset
	input wire logic       ref_clk_in,
	input wire logic       resetn_in,
	// Register bus
	input wire logic       hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic       hwrite_in,
	input wire logic       hready_in,
	input wire logic       hreadyout_out,
	input wire logic       hresp_out,
	// Data side
	input wire logic       ds_done_out,
	input wire logic       ds_busy_out,
	input wire logic       ds_mem_en_out,
	input wire logic [3:0] ds_attr_out,
	input wire logic       ds_miss_out,
	input wire logic       ds_fault_out,
	// Instruction side
	input wire logic       if_done_out,
	input wire logic       if_busy_out,
	input wire logic       if_mem_en_out,
	input wire logic       if_miss_out,
	input wire logic       if_exec_in,
	input wire logic       if_exec_tag_in,
	input wire logic       instr_storage_fault_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	a_read_one_wait: assert property (hsel_in && htrans_in[1] && hready_in
		&& !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (hsel_in && htrans_in[1] && hready_in
		&& hwrite_in |=> hreadyout_out)
		else $error("write was stalled");
	a_resp_okay: assert property (!hresp_out)
		else $error("error response seen");
	a_ds_walk_three: assert property (
		$rose(ds_busy_out) && !$past(if_busy_out)
		|-> ds_busy_out[*3] ##1 (ds_done_out && !ds_busy_out))
		else $error("data walk length wrong");
	a_if_walk_four: assert property (
		$rose(if_busy_out) && !ds_busy_out
		|-> if_busy_out[*4] ##1 (if_done_out && !if_busy_out))
		else $error("instruction walk length wrong");
	a_data_first: assert property (
		$rose(ds_busy_out) && $rose(if_busy_out)
		|-> !if_done_out[*4] ##1 if_busy_out)
		else $error("instruction side not held back");
	a_ds_suppress: assert property (
		ds_done_out && (ds_miss_out || ds_fault_out) |-> !ds_mem_en_out)
		else $error("faulting data access went out");
	a_if_suppress: assert property (
		if_done_out && if_miss_out |-> !if_mem_en_out)
		else $error("missing fetch went out");
	a_attr_gated: assert property (
		ds_done_out && ds_fault_out |-> ds_attr_out == 4'h0)
		else $error("attributes applied on denied access");
	a_exec_fault: assert property (
		if_exec_in && if_exec_tag_in |=> instr_storage_fault_out)
		else $error("fault missing at execution");
	a_fault_cause: assert property (
		instr_storage_fault_out |-> $past(if_exec_in && if_exec_tag_in))
		else $error("fault without execution");
endmodule

bind tlb_lookup_access_check lookup_checker i_lookup_checker (.*);

// file: verification/pipe_stage_model.sv
// Purpose: Fetch and load/store stage model issuing lookups.
// Assumes: Caller enters a task right after a rising edge, side idle.
// Notes:   Address lines carry inverted data outside a request.
`timescale 1ns/1ns
module pipe_stage_model (
	// Clock
	input  wire logic          ref_clk_in,
	// Data side
	input  wire logic          ds_done_in,
	output logic               ds_req_out,
	output logic [31:0]        ds_ea_out,
	output tlb_check_pkg::op_t ds_op_out,
	// Instruction side
	input  wire logic          if_done_in,
	output logic               if_req_out,
	output logic [31:0]        if_ea_out
);
	import tlb_check_pkg::*;
	int ds_lat;
	int if_lat;
	initial begin
		ds_req_out = 1'b0;
		ds_ea_out = 32'h0;
		ds_op_out = OP_LOAD;
		if_req_out = 1'b0;
		if_ea_out = 32'h0;
	end
	task automatic dreq(input logic [31:0] va, input op_t op);
		ds_lat = 0;
		ds_req_out <= 1'b1;
		ds_ea_out <= va;
		ds_op_out <= op;
		@(posedge ref_clk_in);
		ds_req_out <= 1'b0;
		ds_ea_out <= ~va;
		do begin
			@(posedge ref_clk_in);
			ds_lat++;
		end while (!ds_done_in);
	endtask
	task automatic ireq(input logic [31:0] va);
		if_lat = 0;
		if_req_out <= 1'b1;
		if_ea_out <= va;
		@(posedge ref_clk_in);
		if_req_out <= 1'b0;
		if_ea_out <= ~va;
		do begin
			@(posedge ref_clk_in);
			if_lat++;
		end while (!if_done_in);
	endtask
endmodule

// file: verification/test_tlb_lookup_access_check.sv
// Purpose: Self-checking bench for the translation lookup block.
// Assumes: Register offsets come from the shared header.
// Notes:   Page addresses are random from a fixed seed.
`timescale 1ns/1ns
`include "tlb_check_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	err_count++; $display("mismatch %0t got %h want %h", $time, a, b); \
	end end
module test_tlb_lookup_access_check;
	import tlb_check_pkg::*;
	logic        ref_clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        hsel_in = 1'b0;
	logic [31:0] haddr_in = 32'h0;
	logic [1:0]  htrans_in = 2'h0;
	logic        hwrite_in = 1'b0;
	logic [2:0]  hsize_in = 3'h2;
	logic [31:0] hwdata_in = 32'h0;
	logic        hready_in;
	logic        user_mode_in = 1'b0;
	logic        irq_in = 1'b0;
	logic        if_exec_in = 1'b0;
	logic        if_exec_tag_in = 1'b0;
	logic        ds_req_in, if_req_in, hreadyout_out, hresp_out;
	logic [31:0] ds_ea_in, if_ea_in, hrdata_out, ds_pa_out, if_pa_out;
	op_t         ds_op_in;
	logic        ds_done_out, ds_busy_out, ds_mem_en_out, ds_miss_out;
	logic        ds_fault_out, if_done_out, if_busy_out, if_mem_en_out;
	logic        if_miss_out, if_isf_tag_out, instr_storage_fault_out;
	logic [3:0]  ds_attr_out;
	logic [31:0] q;
	int          err_count = 0;
	int          samples_checked = 0;
	assign hready_in = hreadyout_out;
	always #10 ref_clk_in = ~ref_clk_in;

	tlb_lookup_access_check i_tlb_lookup_access_check (.*);
	pipe_stage_model i_pipe_stage_model (
		.ref_clk_in (ref_clk_in),
		.ds_done_in (ds_done_out),
		.ds_req_out (ds_req_in),
		.ds_ea_out  (ds_ea_in),
		.ds_op_out  (ds_op_in),
		.if_done_in (if_done_out),
		.if_req_out (if_req_in),
		.if_ea_out  (if_ea_in)
	);

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel_in <= 1'b1;
		haddr_in <= {24'h0, a};
		htrans_in <= 2'h2;
		hwrite_in <= w;
		do @(posedge ref_clk_in); while (!hready_in);
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge ref_clk_in); while (!hready_in);
		r = hrdata_out;
	endtask
	task automatic ld(input logic [3:0] n, input logic [31:0] hi, lo);
		bus(1'b1, `OFS_ENT_HI, hi, q);
		bus(1'b1, `OFS_ENT_LO, lo, q);
		bus(1'b1, `OFS_ENT_TID, 32'h0, q);
		bus(1'b1, `OFS_ENT_WR, {28'h0, n}, q);
	endtask
	task automatic exec(input logic t);
		if_exec_in <= 1'b1;
		if_exec_tag_in <= t;
		@(posedge ref_clk_in);
		if_exec_in <= 1'b0;
		if_exec_tag_in <= ~t;
		@(posedge ref_clk_in);
	endtask
	function automatic logic [31:0] exp_pa(int s, logic [31:0] rp, va);
		logic [31:0] m;
		m = 32'hffffffff << (10 + 2 * s);
		return (rp & m) | (va & ~m);
	endfunction
	function automatic logic [31:0] zreg(logic [3:0] s, logic [1:0] z);
		zreg = {16{~z}};
		zreg[31 - 2 * s -: 2] = z;
	endfunction
	function automatic logic dfault(logic u, logic [1:0] z, logic w,
		logic ua, op_t o);
		logic wt;
		wt = o == OP_STORE || o == OP_ZERO;
		if (u)
			return (z == 2'h0 && (wt || o inside {OP_LOAD, OP_FLUSH,
				OP_STBACK, OP_ICINV})) || (wt && ((!w && z != 2'h3) || ua));
		wt = wt || o == OP_INVAL || o == OP_CCINV;
		return wt && ((!w && !z[1]) || ua);
	endfunction
	function automatic logic ifault(logic u, logic [1:0] z, logic ex, g);
		return (u && z == 2'h0) || g || (!ex && z != 2'h3 && (u || z != 2'h2));
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge ref_clk_in);
		err_count++;
		conclude();
	end

	initial begin
		logic [31:0] va, rp;
		logic [3:0]  zs;
		logic        f;
		int          l1;
		void'($urandom(11062));
		repeat (3) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		@(posedge ref_clk_in);
		bus(1'b1, 8'h40, 32'hffffffff, q);
		bus(1'b0, 8'h40, 32'h0, q);
		`CHK(q, 32'h0)
		va = $urandom;
		i_pipe_stage_model.dreq(va, OP_STORE);
		`CHK(ds_pa_out, va)
		`CHK(ds_attr_out, 4'h0)
		bus(1'b1, `OFS_CTRL, 32'h3, q);
		for (int s = 0; s < 8; s++) begin
			va = {s[2:0], 1'b0, 28'($urandom)};
			rp = $urandom & (32'hffffffff << (10 + 2 * s));
			bus(1'b1, `OFS_PID, s[0] ? 32'h33 : 32'h0, q);
			ld(4'(s), {va[31:10], s[2:0], 7'h40}, {rp[31:10], 10'h300});
			va = va ^ ($urandom & ~(32'hffffffff << (10 + 2 * s)));
			i_pipe_stage_model.dreq(va, OP_LOAD);
			l1 = i_pipe_stage_model.ds_lat;
			`CHK(ds_pa_out, exp_pa(s, rp, va))
			i_pipe_stage_model.dreq(va, OP_LOAD);
			`CHK(i_pipe_stage_model.ds_lat < l1, 1'b1)
			`CHK(ds_pa_out, exp_pa(s, rp, va))
			i_pipe_stage_model.ireq(va);
			`CHK(if_pa_out, exp_pa(s, rp, va))
		end
		ld(4'ha, {22'h140000, 10'h040}, 32'h300);
		bus(1'b1, `OFS_ENT_TID, 32'h5, q);
		bus(1'b1, `OFS_ENT_WR, 32'ha, q);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, `OFS_PID, i == 0 ? 32'h5 : 32'h7 * (2 - i), q);
			i_pipe_stage_model.dreq(32'h50000000, OP_STORE);
			`CHK(ds_miss_out, i != 0)
			`CHK(ds_mem_en_out, i == 0)
		end
		i_pipe_stage_model.dreq(32'h30000000, OP_TOUCH);
		`CHK(ds_miss_out, 1'b0)
		i_pipe_stage_model.ireq(32'h30000000);
		`CHK(if_miss_out, 1'b1)
		for (int k = 0; k < 8; k++) begin
			zs = 4'($urandom);
			bus(1'b1, `OFS_CFG, {31'h0, k[2]}, q);
			ld(4'hb, {22'h340001, 5'h2, k[1], 4'h0}, {23'h1, k[0], zs, 4'h9});
			for (int u = 0; u < 2; u++)
				for (int z = 0; z < 4; z++) begin
					user_mode_in <= u[0];
					bus(1'b1, `OFS_ZONE, zreg(zs, z[1:0]), q);
					for (int o = 0; o < 10; o++) begin
						f = dfault(u[0], z[1:0], k[0], k[1] & k[2], op_t'(o));
						i_pipe_stage_model.dreq(32'hd0000400, op_t'(o));
						`CHK(ds_fault_out, f)
						if (o != 9) begin
							`CHK(ds_attr_out, f ? 4'h0 : 4'h5)
							`CHK(ds_mem_en_out, !f)
						end
					end
				end
		end
		for (int k = 0; k < 4; k++) begin
			zs = 4'($urandom);
			ld(4'hc, {22'h3c0002, 10'h040}, {22'h0, k[0], 1'b1, zs, 3'h0, k[1]});
			for (int u = 0; u < 2; u++)
				for (int z = 0; z < 4; z++) begin
					f = ifault(u[0], z[1:0], k[0], k[1]);
					user_mode_in <= u[0];
					bus(1'b1, `OFS_ZONE, zreg(zs, z[1:0]), q);
					i_pipe_stage_model.ireq(32'hf0000800);
					`CHK(if_isf_tag_out, f)
					`CHK(instr_storage_fault_out, 1'b0)
					exec(f);
					`CHK(instr_storage_fault_out, f)
				end
		end
		bus(1'b1, `OFS_ENT_WR, 32'hc, q);
		fork
			i_pipe_stage_model.dreq(32'hd0000400, OP_LOAD);
			i_pipe_stage_model.ireq(32'hf0000800);
		join
		`CHK(ds_pa_out, 32'h0)
		`CHK(if_pa_out, 32'h0)
		l1 = i_pipe_stage_model.ds_lat + 4;
		`CHK(i_pipe_stage_model.if_lat >= l1, 1'b1)
		irq_in <= 1'b1;
		@(posedge ref_clk_in);
		irq_in <= 1'b0;
		bus(1'b0, `OFS_CTRL, 32'h0, q);
		`CHK(q, 32'h0)
		i_pipe_stage_model.dreq(32'h30000000, OP_LOAD);
		`CHK(ds_pa_out, 32'h30000000)
		bus(1'b0, `OFS_STATUS, 32'h0, q);
		`CHK(q, 32'h8)
		conclude();
	end
endmodule
